/* File: bench/mrs_slave_sva.sv */
// Concurrent checks on the ports of the register command interpreter.
`timescale 1ns/10ps
module mrs_slave_sva
    import mrs_pkg::*;
(
    // Watched ports
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  module_addr,
    input wire mrs_byte_s   rx,
    input wire mrs_byte_s   tx,
    input wire logic        tx_ready,
    input wire mrs_reg_s    reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic        clr_pulse,
    input wire logic [4:0]  clr_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire wr_ok = (reg_req.index <= WR_A_LAST) || (reg_req.index >= WR_B_FIRST && reg_req.index <= WR_B_LAST);
    property p_tx_one; tx.valid |=> !tx.valid; endproperty
    a_tx_one: assert property (p_tx_one)
        else $error("transmit strobe longer than one cycle");
    property p_tx_ready; tx.valid |-> $past(tx_ready); endproperty
    a_tx_ready: assert property (p_tx_ready)
        else $error("byte sent while uart not ready");
    property p_rx_quiet; rx.valid |=> !tx.valid [*8]; endproperty
    a_rx_quiet: assert property (p_rx_quiet)
        else $error("reply started before packet silence");
    property p_we_one; reg_req.we |=> !reg_req.we; endproperty
    a_we_one: assert property (p_we_one)
        else $error("store write longer than one cycle");
    property p_we_span; reg_req.we |-> wr_ok && !clr_pulse; endproperty
    a_we_span: assert property (p_we_span)
        else $error("store write outside writable spans");
    property p_clr_one; clr_pulse |=> !clr_pulse; endproperty
    a_clr_one: assert property (p_clr_one)
        else $error("clear pulse longer than one cycle");
    property p_clr_span; clr_pulse |-> clr_sel <= 5'h15; endproperty
    a_clr_span: assert property (p_clr_span)
        else $error("clear select beyond reset span");
    property p_idle_addr; (module_addr == 8'h00 || module_addr > ADDR_MAX) |-> !tx.valid; endproperty
    a_idle_addr: assert property (p_idle_addr)
        else $error("reply sent with illegal module number");
endmodule : mrs_slave_sva

bind mrs_slave mrs_slave_sva u_mrs_slave_sva (.clk(clk), .resetn(resetn), .module_addr(module_addr), .rx(rx),
    .tx(tx), .tx_ready(tx_ready), .reg_req(reg_req), .reg_rdata(reg_rdata), .clr_pulse(clr_pulse),
    .clr_sel(clr_sel));

/* File: bench/mrs_slave_tb.sv */
// Self-checking bench for the register command interpreter.
`timescale 1ns/10ps
module mrs_slave_tb;
    import mrs_pkg::*;
    typedef struct packed {logic [7:0] fc; logic [15:0] idx; logic [15:0] val; logic [7:0] exc;} mrs_row_s;
    localparam logic [7:0] ME = 8'h0B;
    localparam mrs_row_s ROWS [24] = '{
        {8'h03, 16'h0000, 16'h0001, 8'h00}, {8'h03, 16'h00A3, 16'h0002, 8'h00}, {8'h03, 16'h00A4, 16'h0002, 8'h02},
        {8'h03, 16'h00A5, 16'h0001, 8'h02}, {8'h06, 16'h0000, 16'h1111, 8'h00}, {8'h06, 16'h001E, 16'h2222, 8'h00},
        {8'h06, 16'h001F, 16'h3333, 8'h00}, {8'h06, 16'h002B, 16'h4444, 8'h00}, {8'h06, 16'h0047, 16'h5555, 8'h00},
        {8'h06, 16'h0048, 16'h012C, 8'h00}, {8'h06, 16'h006C, 16'hFE0C, 8'h00}, {8'h06, 16'h002C, 16'h7777, 8'h02},
        {8'h06, 16'h0046, 16'h7777, 8'h02}, {8'h06, 16'h006D, 16'h7777, 8'h02}, {8'h03, 16'h001E, 16'h0002, 8'h00},
        {8'h03, 16'h0047, 16'h0002, 8'h00}, {8'h05, 16'h00A5, 16'hFF00, 8'h00}, {8'h05, 16'h00BA, 16'hFF00, 8'h00},
        {8'h05, 16'h00AA, 16'h0000, 8'h00}, {8'h05, 16'h00AA, 16'h1234, 8'h02}, {8'h05, 16'h00BB, 16'hFF00, 8'h02},
        {8'h04, 16'h0000, 16'h0001, 8'h01}, {8'h03, 16'h0000, 16'h0000, 8'h02}, {8'h03, 16'h0000, 16'h007E, 8'h02}};
    logic        clk, resetn, tx_ready, clr_pulse;
    logic [7:0]  module_addr;
    mrs_byte_s   rx, tx;
    mrs_reg_s    reg_req;
    logic [15:0] reg_rdata, shadow [256];
    logic [4:0]  clr_sel, sel;
    logic [7:0]  rq [$], ex [$];
    int          num_errors, samples_checked, nclr;
    logic        stall = 1'b0;
    logic [1:0]  rdy_cnt = 2'd0;

    // Under stall the transmitter is ready only one cycle in four, so the reply must wait for it.
    always @(posedge clk) begin
        rdy_cnt  <= rdy_cnt + 2'd1;
        tx_ready <= !stall || (rdy_cnt == 2'd0);
    end

    mrs_slave #(.BAUD(2_500_000)) u_mrs_slave (.clk(clk), .resetn(resetn), .module_addr(module_addr), .rx(rx),
        .tx(tx), .tx_ready(tx_ready), .reg_req(reg_req), .reg_rdata(reg_rdata), .clr_pulse(clr_pulse),
        .clr_sel(clr_sel));
    mrs_store_model u_mrs_store_model (.clk(clk), .resetn(resetn), .req(reg_req), .rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Sends one request and gathers whatever reply follows within a fixed window.
    task automatic xfer(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] i, input logic [15:0] v,
                        input logic bad);
        logic [7:0]  b [$];
        logic [15:0] c;
        b = '{a, fc, i[15:8], i[7:0], v[15:8], v[7:0]};
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        rq.delete();
        nclr = 0;
        @(posedge clk);
        foreach (b[k]) begin
            rx <= '{1'b1, b[k]};
            @(posedge clk);
            rx <= '{1'b0, ~b[k]};
            repeat (3) @(posedge clk);
        end
        for (int n = 0; n < 1500; n++) begin
            @(negedge clk);
            if (tx.valid === 1'b1) rq.push_back(tx.data);
            if (clr_pulse === 1'b1) begin
                nclr++;
                sel = clr_sel;
            end
        end
    endtask : xfer

    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] c;
        mrs_row_s    r;
        resetn = 1'b0;
        module_addr = ME;
        rx = '0;
        num_errors = 0;
        samples_checked = 0;
        for (int i = 0; i < 256; i++) shadow[i] = 16'h1000 + 16'(i);
        repeat (4) @(posedge clk);
        chk("outputs in reset", {13'h0000, tx.valid, reg_req.we, clr_pulse}, 16'h0000);
        resetn <= 1'b1;
        foreach (ROWS[j]) begin
            r = ROWS[j];
            xfer(ME, r.fc, r.idx, r.val, 1'b0);
            ex = '{ME, (r.exc != 8'h00) ? (r.fc | FC_ERR_BIT) : r.fc};
            if (r.exc != 8'h00) ex.push_back(r.exc);
            else if (r.fc == FC_READ) begin
                ex.push_back(8'(2 * r.val));
                for (int k = 0; k < r.val; k++) begin
                    ex.push_back(shadow[r.idx + k][15:8]);
                    ex.push_back(shadow[r.idx + k][7:0]);
                end
            end else begin
                ex = '{ME, r.fc, r.idx[15:8], r.idx[7:0], r.val[15:8], r.val[7:0]};
                if (r.fc == FC_WRITE) shadow[r.idx[7:0]] = r.val;
            end
            c = crc16(ex);
            ex.push_back(c[7:0]);
            ex.push_back(c[15:8]);
            chk("reply length", 16'(rq.size()), 16'(ex.size()));
            foreach (ex[k]) if (k < rq.size()) chk("reply byte", {8'h00, rq[k]}, {8'h00, ex[k]});
            c = (r.fc == FC_RESET && r.exc == 8'h00 && r.val == COIL_ON) ? 16'h0001 : 16'h0000;
            chk("clear pulses", 16'(nclr), c);
            if (c == 16'h0001) chk("clear select", {11'h000, sel}, r.idx - RST_FIRST);
        end
        // A foreign address, a corrupt check word and an illegal module number all stay silent.
        xfer(8'h0C, FC_WRITE, 16'h0000, 16'h9999, 1'b0);
        chk("foreign reply", 16'(rq.size()), 16'h0000);
        xfer(ME, FC_WRITE, 16'h0000, 16'h9999, 1'b1);
        chk("bad crc reply", 16'(rq.size()), 16'h0000);
        xfer(ME, FC_READ, 16'h0000, 16'h0001, 1'b0);
        chk("no store on bad crc", {rq[3], rq[4]}, shadow[0]);
        @(posedge clk);
        module_addr <= 8'h00;
        xfer(8'h00, FC_READ, 16'h0000, 16'h0001, 1'b0);
        chk("zero address reply", 16'(rq.size()), 16'h0000);
        @(posedge clk);
        module_addr <= ME;
        resetn <= 1'b0;
        @(negedge clk);
        chk("outputs in reset", {13'h0000, tx.valid, reg_req.we, clr_pulse}, 16'h0000);
        // After a reset in mid-run the block answers again, here with a slow transmitter.
        @(posedge clk);
        resetn <= 1'b1;
        stall <= 1'b1;
        xfer(ME, FC_READ, 16'h0000, 16'h0001, 1'b0);
        chk("reply after reset", 16'(rq.size()), 16'h0007);
        chk("store after reset", {rq[3], rq[4]}, 16'h1000);
        final_report();
    end
endmodule : mrs_slave_tb

/* File: bench/mrs_store_model.sv */
// Behavioural register store answering the interpreter's reads and writes.
`timescale 1ns/10ps
module mrs_store_model
    import mrs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Store access
    input  wire mrs_reg_s    req,
    output logic      [15:0] rdata
);
    logic [15:0] mem_r [256];
    // Beyond the table the data moves with the index, so a stale value never passes.
    assign rdata = (req.index < 16'h0100) ? mem_r[req.index[7:0]] : ~req.index;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 256; i++) mem_r[i] <= 16'h1000 + 16'(i);
        end else if (req.we) begin
            mem_r[req.index[7:0]] <= req.wdata;
        end
    end
endmodule : mrs_store_model

/* File: src/mrs_crc.sv */
// Bytewise CRC-16 accumulator used for both check and generation.
`timescale 1ns/10ps
module mrs_crc
    import mrs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Control
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic [7:0]  data,
    // Result
    output logic      [15:0] crc
);

    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc_r <= CRC_INIT;
        end else if (clear) begin
            crc_r <= CRC_INIT;
        end else if (load) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;

endmodule : mrs_crc

/* File: src/mrs_pkg.sv */
// Package of constants and carrier types for the register command interpreter.
// Contract
// - Read serves indices 0 to 164 only.
// - Read reply: address, code, byte count, data, CRC.
// - Every register is sixteen bits wide.
// - Code 5 FF00 in 165..186 clears latch.
// - Code 5 value zero accepted, no change.
// - Other code 5 values or indices rejected.
// - Reset reply echoes index and value.
// - Single write only 0-30, 31-43, 71-108.
// - Single write stores, then echoes fields.
// - Answer only own module number 1..250.
// - Bad CRC packet dropped silently.
// - Packet ends after 3.5 character silence.
// - Error reply: code plus 128, exception.
package mrs_pkg;

    // ----------------------------------------------------------------
    // Codes and index spans
    // ----------------------------------------------------------------
    localparam logic [7:0]  FC_READ      = 8'h03;
    localparam logic [7:0]  FC_RESET     = 8'h05;
    localparam logic [7:0]  FC_WRITE     = 8'h06;
    localparam logic [7:0]  FC_ERR_BIT   = 8'h80;
    localparam logic [7:0]  EXC_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_INDEX    = 8'h02;
    localparam logic [15:0] RD_LAST      = 16'h00A4;
    localparam logic [15:0] RST_FIRST    = 16'h00A5;
    localparam logic [15:0] RST_LAST     = 16'h00BA;
    localparam logic [15:0] WR_A_LAST    = 16'h002B;
    localparam logic [15:0] WR_B_FIRST   = 16'h0047;
    localparam logic [15:0] WR_B_LAST    = 16'h006C;
    localparam logic [15:0] HEATER_STEP  = 16'h00BE;
    localparam logic [15:0] COIL_ON      = 16'hFF00;
    localparam logic [15:0] COIL_OFF     = 16'h0000;
    localparam logic [7:0]  ADDR_MAX     = 8'hFA;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam int          REG_COUNT    = 190;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CHAR_BITS       = 10;
    localparam int SILENCE_TENTHS  = 35;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } mrs_byte_s;

    typedef struct packed {
        logic        we;
        logic [15:0] index;
        logic [15:0] wdata;
    } mrs_reg_s;

endpackage : mrs_pkg

/* File: src/mrs_slave.sv */
// Register command interpreter: parses a packet, executes codes 3, 5 and 6, builds the reply.
`timescale 1ns/10ps
module mrs_slave
    import mrs_pkg::*;
#(
    parameter int CLK_HZ  = 25_000_000,
    parameter int BAUD    = 9600,
    parameter int MAX_LEN = 8
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Configuration
    input  wire logic [7:0]  module_addr,
    // Received bytes from the UART, same clock
    input  wire mrs_byte_s   rx,
    // Transmit bytes toward the UART
    output mrs_byte_s        tx,
    input  wire logic        tx_ready,
    // Register store access
    output mrs_reg_s         reg_req,
    input  wire logic [15:0] reg_rdata,
    // Latched alarm and statistic clear pulse
    output logic             clr_pulse,
    output logic [4:0]       clr_sel
);

    // ----------------------------------------------------------------
    // Timing derived from the line rate
    // ----------------------------------------------------------------
    localparam int SILENCE_CYC = (CLK_HZ / BAUD) * CHAR_BITS * SILENCE_TENTHS / 10;
    localparam int TW          = $clog2(SILENCE_CYC + 1);

    // Only eight-byte frames are decoded, so any other buffer depth is refused.
    if (MAX_LEN != 8 || BAUD <= 0 || CLK_HZ < BAUD) begin : g_bad_params
        $error("mrs_slave: unsupported parameters");
    end

    typedef enum logic [4:0] {
        ST_RECV  = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_EXEC  = 5'b00100,
        ST_SEND  = 5'b01000,
        ST_CRC   = 5'b10000
    } mrs_state_e;

    mrs_state_e  state_r;
    logic [7:0]  buf_r [MAX_LEN];
    logic [3:0]  len_r;
    logic [TW-1:0] gap_r;
    logic        ovf_r;
    logic [7:0]  pos_r;
    logic [7:0]  tx_len_r;
    logic [15:0] idx_r;
    logic [7:0]  exc_r;
    logic        err_r;
    logic        crc_hi_r;
    logic [15:0] tx_crc_r;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire [7:0]  f_addr   = buf_r[0];
    wire [7:0]  f_code   = buf_r[1];
    wire [15:0] f_index  = {buf_r[2], buf_r[3]};
    wire [15:0] f_value  = {buf_r[4], buf_r[5]};
    wire [15:0] f_crc    = {buf_r[7], buf_r[6]};
    wire [16:0] rd_end   = {1'b0, f_index} + {1'b0, f_value};
    wire        addr_ok  = (f_addr == module_addr) && (module_addr != 8'h00) && (module_addr <= ADDR_MAX);
    wire        len_ok   = (len_r == 4'd8) && !ovf_r;
    wire        rd_ok    = (f_value != 16'h0000) && (f_value <= 16'h007D)
                           && (rd_end <= {1'b0, RD_LAST} + 17'd1);
    wire        rst_span = (f_index >= RST_FIRST) && (f_index <= RST_LAST);
    wire        rst_ok   = rst_span && ((f_value == COIL_ON) || (f_value == COIL_OFF));
    wire        wr_ok    = (f_index <= WR_A_LAST)
                           || ((f_index >= WR_B_FIRST) && (f_index <= WR_B_LAST));
    wire        code_ok  = (f_code == FC_READ) || (f_code == FC_RESET) || (f_code == FC_WRITE);
    wire        op_ok    = (f_code == FC_READ) ? rd_ok : (f_code == FC_RESET) ? rst_ok : wr_ok;
    wire        gap_done = (gap_r == TW'(SILENCE_CYC));

    // ----------------------------------------------------------------
    // CRC engine shared by check and reply
    // ----------------------------------------------------------------
    logic [7:0]  tx_byte;
    logic [15:0] crc_val;
    wire         tx_fire  = (state_r == ST_SEND || state_r == ST_CRC) && tx_ready && !tx.valid;
    // The residue must survive the silence until the check, and the reply's sum must not seed the next frame.
    wire         crc_clr  = (state_r == ST_CHECK) || (state_r == ST_CRC && tx_fire && crc_hi_r);
    wire         crc_load = (state_r == ST_RECV && rx.valid) || (state_r == ST_SEND && tx_fire);
    wire [7:0]   crc_in   = (state_r == ST_SEND) ? tx_byte : rx.data;

    mrs_crc u_crc (
        .clk    (clk),
        .resetn (resetn),
        .clear  (crc_clr),
        .load   (crc_load),
        .data   (crc_in),
        .crc    (crc_val)
    );

    // ----------------------------------------------------------------
    // Reply byte selection
    // ----------------------------------------------------------------
    wire [7:0] rd_pos = pos_r - 8'd3;
    always_comb begin
        tx_byte = 8'h00;
        if (pos_r == 8'd0) begin
            tx_byte = f_addr;
        end else if (pos_r == 8'd1) begin
            tx_byte = err_r ? (f_code | FC_ERR_BIT) : f_code;
        end else if (err_r) begin
            tx_byte = exc_r;
        end else if (f_code == FC_READ) begin
            if (pos_r == 8'd2) begin
                tx_byte = {f_value[6:0], 1'b0};
            end else begin
                tx_byte = rd_pos[0] ? reg_rdata[7:0] : reg_rdata[15:8];
            end
        end else begin
            tx_byte = buf_r[pos_r[2:0]];
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r  <= ST_RECV;
            len_r    <= 4'd0;
            gap_r    <= '0;
            ovf_r    <= 1'b0;
            pos_r    <= 8'd0;
            tx_len_r <= 8'd0;
            idx_r    <= 16'h0000;
            exc_r    <= 8'h00;
            err_r    <= 1'b0;
            crc_hi_r <= 1'b0;
            tx_crc_r <= 16'h0000;
            tx       <= '0;
            reg_req  <= '0;
            clr_pulse <= 1'b0;
            clr_sel  <= 5'd0;
            for (int i = 0; i < MAX_LEN; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else begin
            tx.valid  <= 1'b0;
            reg_req.we <= 1'b0;
            clr_pulse <= 1'b0;
            unique case (state_r)
                ST_RECV: begin
                    if (rx.valid) begin
                        gap_r <= '0;
                        if (len_r < 4'(MAX_LEN)) begin
                            buf_r[len_r[2:0]] <= rx.data;
                            len_r <= len_r + 4'd1;
                        end else begin
                            ovf_r <= 1'b1;
                        end
                    end else if (len_r != 4'd0) begin
                        if (gap_done) begin
                            state_r <= ST_CHECK;
                        end else begin
                            gap_r <= gap_r + TW'(1);
                        end
                    end
                end
                ST_CHECK: begin
                    len_r <= 4'd0;
                    ovf_r <= 1'b0;
                    gap_r <= '0;
                    // Frames that fail the check or are not ours get no reply, store write or clear pulse; exc_r, err_r, idx_r and pos_r still load.
                    if (len_ok && addr_ok && crc_val == 16'h0000) begin
                        state_r <= ST_EXEC;
                    end else begin
                        state_r <= ST_RECV;
                    end
                    exc_r <= code_ok ? EXC_INDEX : EXC_FUNC;
                    err_r <= !(code_ok && op_ok);
                    idx_r <= f_index;
                    pos_r <= 8'd0;
                end
                ST_EXEC: begin
                    if (!err_r && f_code == FC_WRITE) begin
                        reg_req <= '{we: 1'b1, index: f_index, wdata: f_value};
                    end
                    if (!err_r && f_code == FC_RESET && f_value == COIL_ON) begin
                        clr_pulse <= 1'b1;
                        clr_sel   <= 5'(f_index - RST_FIRST);
                    end
                    if (err_r) begin
                        tx_len_r <= 8'd3;
                    end else if (f_code == FC_READ) begin
                        tx_len_r <= 8'd3 + {f_value[6:0], 1'b0};
                    end else begin
                        tx_len_r <= 8'd6;
                    end
                    state_r <= ST_SEND;
                end
                ST_SEND: begin
                    reg_req.index <= idx_r;
                    if (tx_fire) begin
                        tx <= '{valid: 1'b1, data: tx_byte};
                        pos_r <= pos_r + 8'd1;
                        if (f_code == FC_READ && !err_r && pos_r >= 8'd3 && rd_pos[0]) begin
                            idx_r <= idx_r + 16'd1;
                        end
                        if (pos_r + 8'd1 == tx_len_r) begin
                            state_r  <= ST_CRC;
                            crc_hi_r <= 1'b0;
                        end
                    end
                end
                ST_CRC: begin
                    // The last reply byte enters the CRC on the edge into this state, so crc_val is complete here and is latched for the high byte.
                    if (!crc_hi_r) begin
                        tx_crc_r <= crc_val;
                    end
                    if (tx_fire) begin
                        tx <= '{valid: 1'b1, data: crc_hi_r ? tx_crc_r[15:8] : crc_val[7:0]};
                        crc_hi_r <= 1'b1;
                        if (crc_hi_r) begin
                            state_r <= ST_RECV;
                        end
                    end
                end
            endcase
        end
    end

endmodule : mrs_slave
